/* File: design/tcc_pkg.sv */
// Constants, register map and carrier types of the 16-bit timer control.
// Assumes one 100 MHz clock that stands for the base oscillator.
// Functional notes
// - Counter runs while mode bits are nonzero; mode zero stops and clears it.
// - Mode 00 stop, 01 free, 10 clear on input zero edge, 11 on match zero.
// - Toggle timing bit 1 adds input zero valid edge as output toggle source.
// - Matches with either register raise an event in running modes only.
// - With register zero at FFFFH, wrap FFFFH to 0000H sets overflow flag.
// - Capture select bit 2 makes register one a capture register.
// - Trigger select 0 captures on input one edge, 1 on opposite input zero.
// - Capture select bit 0 makes register zero a capture register.
// - No register zero capture on input zero edge when both edges are selected.
// - Writing one-shot trigger fires a pulse; the bit self-clears, reads 0.
// - One-shot mode bit selects one-shot output; not usable in match-clear mode.
// - Separate enables let match one and match zero toggle the output.
// - Level command 01 clears, 10 sets, 11 prohibited; both bits read 0.
// - Output enable 0 holds pin low; enable 1 drives the flip-flop.
// - Clock select: osc/2, osc/4, osc/256, or input zero valid edges.
// - Edge select: 00 falling, 01 rising, 11 both, 10 prohibited.
// - Input zero as clock needs two-oscillator-cycle pulses, clock at most 10 MHz.
// - Reset clears mode, capture, output and prescaler registers to 00H.
package tcc_pkg;
	localparam int ADDR_W = 16;
	localparam logic [15:0] ADDR_CAPCTL = 16'hFF6A;
	localparam logic [15:0] ADDR_OUTCTL = 16'hFF6B;
	localparam logic [15:0] ADDR_MODE = 16'hFF7E;
	localparam logic [15:0] ADDR_PRESC = 16'hFF7F;
	// Own choice: 16-bit registers as byte pairs, low byte first
	localparam logic [15:0] ADDR_CR0_LO = 16'hFF60;
	localparam logic [15:0] ADDR_CR0_HI = 16'hFF61;
	localparam logic [15:0] ADDR_CR1_LO = 16'hFF62;
	localparam logic [15:0] ADDR_CR1_HI = 16'hFF63;
	localparam logic [15:0] ADDR_CNT_LO = 16'hFF64;
	localparam logic [15:0] ADDR_CNT_HI = 16'hFF65;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// Mode register bits
	localparam int MODE_OVF = 0;
	localparam int MODE_TOG_TIMING = 1;
	localparam int MODE_LO = 2;
	localparam int MODE_HI = 3;
	// Capture control bits
	localparam int CAP_REG0 = 0;
	localparam int CAP_TRIG0 = 1;
	localparam int CAP_REG1 = 2;
	// Output control bits
	localparam int OUT_EN = 0;
	localparam int OUT_TOG0 = 1;
	localparam int OUT_CLR = 2;
	localparam int OUT_SET = 3;
	localparam int OUT_TOG1 = 4;
	localparam int OUT_OS_MODE = 5;
	localparam int OUT_OS_TRIG = 6;
	localparam logic [7:0] OUT_WMASK = 8'h33;
	// Prescaler bits
	localparam int PRE_CLK_LO = 0;
	localparam int PRE_EDGE0_LO = 4;
	localparam int PRE_EDGE1_LO = 6;
	localparam logic [7:0] PRE_WMASK = 8'hF3;
	localparam logic [7:0] CAP_WMASK = 8'h07;
	localparam logic [7:0] MODE_WMASK = 8'h0F;
	// Prescaler taps: osc/2, osc/4, osc/256
	localparam int PRESC_W = 8;
	localparam int TAP_DIV2 = 0;
	localparam int TAP_DIV4 = 1;
	localparam int TAP_DIV256 = 7;
	typedef enum logic [1:0] {
		TCC_STOP, TCC_FREE, TCC_EDGE_CLR, TCC_MATCH_CLR
	} tcc_mode_type;
	typedef enum logic [1:0] {
		TCC_FALL, TCC_RISE, TCC_BAD, TCC_BOTH
	} tcc_edge_type;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tcc_bus_type;
	typedef struct packed {
		logic match0;
		logic match1;
	} tcc_irq_type;
endpackage : tcc_pkg

/* File: design/tcc_timer.sv */
// 16-bit timer/event counter with two capture/compare registers.
// Assumes a same-clock register port; input pins are asynchronous.
`timescale 1ns/1ns
module tcc_timer
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire tcc_bus_type bus,
	output logic [7:0] rdata,
	// Pins
	input wire logic timer_input_zero,
	input wire logic timer_input_one,
	output logic timer_output_pin,
	// Events
	output tcc_irq_type irq
);
	logic [7:0] mode_q;
	logic [7:0] cap_q;
	logic [7:0] out_q;
	logic [7:0] pre_q;
	logic [15:0] main_counter_q;
	logic [15:0] capcmp_reg_zero_q;
	logic [15:0] capcmp_reg_one_q;
	logic [PRESC_W-1:0] div_q;
	logic [1:0] in0_sync_q;
	logic [1:0] in1_sync_q;
	logic in0_prev_q;
	logic in1_prev_q;
	logic in0_seen_q;
	logic out_ff_q;
	logic oneshot_armed_q;
	logic [7:0] rdata_q;
	logic [PRESC_W-1:0] div_d;
	logic tick;
	logic in0_rise;
	logic in0_fall;
	logic in1_rise;
	logic in1_fall;
	logic in0_valid;
	logic in1_valid;
	logic in0_capture;
	logic running;
	logic match0;
	logic match1;
	logic wrap;
	logic soft_trig;
	logic cnt_clear;
	logic [15:0] cnt_next;
	tcc_mode_type mode;
	tcc_edge_type edge0;
	tcc_edge_type edge1;
	// Register strobes, decoded once for every block below
	logic wr_mode;
	logic wr_cap;
	logic wr_out;
	logic wr_pre;
	logic wr_cr0_lo;
	logic wr_cr0_hi;
	logic wr_cr1_lo;
	logic wr_cr1_hi;
	logic lvl_clr;
	logic lvl_set;
	logic cap0_trig;
	logic cap1_trig;
	logic ovf_set;

	assign mode = tcc_mode_type'(mode_q[MODE_HI:MODE_LO]);
	assign edge0 = tcc_edge_type'(pre_q[PRE_EDGE0_LO +: 2]);
	assign edge1 = tcc_edge_type'(pre_q[PRE_EDGE1_LO +: 2]);
	assign running = (mode != TCC_STOP);

	assign wr_mode = bus.wr & (bus.addr == ADDR_MODE);
	assign wr_cap = bus.wr & (bus.addr == ADDR_CAPCTL);
	assign wr_out = bus.wr & (bus.addr == ADDR_OUTCTL);
	assign wr_pre = bus.wr & (bus.addr == ADDR_PRESC);
	assign wr_cr0_lo = bus.wr & (bus.addr == ADDR_CR0_LO);
	assign wr_cr0_hi = bus.wr & (bus.addr == ADDR_CR0_HI);
	assign wr_cr1_lo = bus.wr & (bus.addr == ADDR_CR1_LO);
	assign wr_cr1_hi = bus.wr & (bus.addr == ADDR_CR1_HI);
	// Prohibited level code 11 matches neither command, so it is ignored
	assign lvl_clr = wr_out & (bus.wdata[OUT_CLR +: 2] == 2'h1);
	assign lvl_set = wr_out & (bus.wdata[OUT_CLR +: 2] == 2'h2);

	// Two flip-flops before any logic sees the pins
	always_ff @(posedge clk) begin
		if (rst) begin
			in0_sync_q <= 2'h0;
			in1_sync_q <= 2'h0;
		end else begin
			in0_sync_q <= {in0_sync_q[0], timer_input_zero};
			in1_sync_q <= {in1_sync_q[0], timer_input_one};
		end
	end

	// Previous level is reloaded while stopped, so restart sees no old edge
	always_ff @(posedge clk) begin
		if (rst) begin
			in0_prev_q <= 1'b0;
			in1_prev_q <= 1'b0;
			in0_seen_q <= 1'b0;
		end else begin
			in0_prev_q <= in0_sync_q[1];
			in1_prev_q <= in1_sync_q[1];
			in0_seen_q <= running;
		end
	end

	assign in0_rise = in0_seen_q & in0_sync_q[1] & ~in0_prev_q;
	assign in0_fall = in0_seen_q & ~in0_sync_q[1] & in0_prev_q;
	assign in1_rise = in0_seen_q & in1_sync_q[1] & ~in1_prev_q;
	assign in1_fall = in0_seen_q & ~in1_sync_q[1] & in1_prev_q;

	// Edge decode; the prohibited code detects nothing
	always_comb begin
		unique case (edge0)
			TCC_FALL: in0_valid = in0_fall;
			TCC_RISE: in0_valid = in0_rise;
			TCC_BOTH: in0_valid = in0_rise | in0_fall;
			TCC_BAD: in0_valid = 1'b0;
		endcase
	end

	always_comb begin
		unique case (edge1)
			TCC_FALL: in1_valid = in1_fall;
			TCC_RISE: in1_valid = in1_rise;
			TCC_BOTH: in1_valid = in1_rise | in1_fall;
			TCC_BAD: in1_valid = 1'b0;
		endcase
	end

	// Opposite phase of input zero, none for both edges
	always_comb begin
		unique case (edge0)
			TCC_FALL: in0_capture = in0_rise;
			TCC_RISE: in0_capture = in0_fall;
			TCC_BOTH: in0_capture = 1'b0;
			TCC_BAD: in0_capture = 1'b0;
		endcase
	end

	// Free divider for the internal count clock; cleared while stopped
	assign div_d = div_q + PRESC_W'(1);
	always_ff @(posedge clk) begin
		if (rst || !running) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	always_comb begin
		unique case (pre_q[PRE_CLK_LO +: 2])
			2'h0: tick = div_d[TAP_DIV2] & ~div_q[TAP_DIV2];
			2'h1: tick = div_d[TAP_DIV4] & ~div_q[TAP_DIV4];
			2'h2: tick = div_d[TAP_DIV256] & ~div_q[TAP_DIV256];
			2'h3: tick = in0_valid;
		endcase
	end

	// Compare only in compare role, and only while running
	assign match0 = running & tick & ~cap_q[CAP_REG0]
		& (main_counter_q == capcmp_reg_zero_q);
	assign match1 = running & tick & ~cap_q[CAP_REG1]
		& (main_counter_q == capcmp_reg_one_q);
	assign wrap = running & tick & (main_counter_q == CNT_MAX);
	// Overflow only counts when register zero spans the full range
	assign ovf_set = wrap & (capcmp_reg_zero_q == CNT_MAX);
	assign soft_trig = wr_out & bus.wdata[OUT_OS_TRIG]
		& out_q[OUT_OS_MODE];
	// Capture triggers; register zero picks its source
	assign cap0_trig = running & cap_q[CAP_REG0]
		& (cap_q[CAP_TRIG0] ? in0_capture : in1_valid);
	assign cap1_trig = running & cap_q[CAP_REG1] & in0_valid;

	always_comb begin
		cnt_clear = 1'b0;
		if (mode == TCC_EDGE_CLR && in0_valid) begin
			cnt_clear = 1'b1;
		end
		if (mode == TCC_MATCH_CLR && match0) begin
			cnt_clear = 1'b1;
		end
		// Match-clear restarts the count on match zero by itself, so a one-shot restart is refused
		if (soft_trig && running && mode != TCC_MATCH_CLR) begin
			cnt_clear = 1'b1;
		end
	end
	assign cnt_next = main_counter_q + 16'h0001;

	always_ff @(posedge clk) begin
		if (rst || !running) begin
			main_counter_q <= 16'h0000;
		end else if (cnt_clear) begin
			main_counter_q <= 16'h0000;
		end else if (tick) begin
			main_counter_q <= cnt_next;
		end
	end

	// One-shot: armed by trigger, one pulse, then held until next trigger
	always_ff @(posedge clk) begin
		if (rst || !running || !out_q[OUT_OS_MODE]) begin
			oneshot_armed_q <= 1'b0;
		end else if (soft_trig) begin
			oneshot_armed_q <= 1'b1;
		end else if (oneshot_armed_q && match0 && out_ff_q) begin
			// The match that brings the pin back low ends the shot
			oneshot_armed_q <= 1'b0;
		end
	end

	// Output flip-flop
	logic tog;
	logic tog_allowed;
	always_comb begin
		tog_allowed = ~out_q[OUT_OS_MODE] | oneshot_armed_q;
		tog = 1'b0;
		if (match0 && out_q[OUT_TOG0]) begin
			tog = 1'b1;
		end
		if (match1 && out_q[OUT_TOG1]) begin
			tog = 1'b1;
		end
		if (mode_q[MODE_TOG_TIMING] && in0_valid && running) begin
			tog = 1'b1;
		end
		// Stopped timer or a spent one-shot masks every source
		if (!running || !tog_allowed) begin
			tog = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		// Software level commands win over a toggle in the same cycle
		if (rst) begin
			out_ff_q <= 1'b0;
		end else if (lvl_clr) begin
			out_ff_q <= 1'b0;
		end else if (lvl_set) begin
			out_ff_q <= 1'b1;
		end else if (tog) begin
			out_ff_q <= ~out_ff_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			timer_output_pin <= 1'b0;
		end else begin
			timer_output_pin <= out_q[OUT_EN] & out_ff_q;
		end
	end

	// Capture beats a software write in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			capcmp_reg_zero_q <= 16'h0000;
		end else if (cap0_trig) begin
			capcmp_reg_zero_q <= main_counter_q;
		end else if (wr_cr0_lo) begin
			capcmp_reg_zero_q[7:0] <= bus.wdata;
		end else if (wr_cr0_hi) begin
			capcmp_reg_zero_q[15:8] <= bus.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			capcmp_reg_one_q <= 16'h0000;
		end else if (cap1_trig) begin
			capcmp_reg_one_q <= main_counter_q;
		end else if (wr_cr1_lo) begin
			capcmp_reg_one_q[7:0] <= bus.wdata;
		end else if (wr_cr1_hi) begin
			capcmp_reg_one_q[15:8] <= bus.wdata;
		end
	end

	// Mode register; overflow set wins over a clearing write
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q <= RESET_BYTE;
		end else begin
			if (wr_mode) begin
				mode_q <= bus.wdata & MODE_WMASK;
			end
			if (ovf_set) begin
				mode_q[MODE_OVF] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cap_q <= RESET_BYTE;
		end else if (wr_cap) begin
			cap_q <= bus.wdata & CAP_WMASK;
		end
	end

	// Command and trigger bits are never stored
	always_ff @(posedge clk) begin
		if (rst) begin
			out_q <= RESET_BYTE;
		end else if (wr_out) begin
			out_q <= bus.wdata & OUT_WMASK;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pre_q <= RESET_BYTE;
		end else if (wr_pre) begin
			pre_q <= bus.wdata & PRE_WMASK;
		end
	end

	// Read mux apart from the flop, so unmapped addresses read zero
	logic [7:0] rd_mux;
	always_comb begin
		unique case (bus.addr)
			ADDR_MODE: rd_mux = mode_q;
			ADDR_CAPCTL: rd_mux = cap_q;
			ADDR_OUTCTL: rd_mux = out_q;
			ADDR_PRESC: rd_mux = pre_q;
			ADDR_CR0_LO: rd_mux = capcmp_reg_zero_q[7:0];
			ADDR_CR0_HI: rd_mux = capcmp_reg_zero_q[15:8];
			ADDR_CR1_LO: rd_mux = capcmp_reg_one_q[7:0];
			ADDR_CR1_HI: rd_mux = capcmp_reg_one_q[15:8];
			ADDR_CNT_LO: rd_mux = main_counter_q[7:0];
			ADDR_CNT_HI: rd_mux = main_counter_q[15:8];
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk) begin
		if (rst || !bus.rd) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rd_mux;
		end
	end
	assign rdata = rdata_q;

	// Match events, with register zero captures on match0, as registered one-cycle pulses
	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= '0;
		end else begin
			irq.match0 <= match0 | cap0_trig;
			irq.match1 <= match1;
		end
	end
endmodule : tcc_timer

/* File: bench/tcc_timer_props.sv */
// Checker for the timer: read port, events and output pin.
// Assumes it is bound to tcc_timer and sees only its ports.
`timescale 1ns/1ns
module tcc_timer_props import tcc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire tcc_bus_type bus,
	input wire logic [7:0] rdata,
	// Pins and events
	input wire logic timer_input_zero,
	input wire logic timer_input_one,
	input wire logic timer_output_pin,
	input wire tcc_irq_type irq
);
	logic en_q;
	logic [1:0] mode_q;
	logic [1:0] stop_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Shadows of enable and mode, since the checker sees no registers
	always_ff @(posedge clk) begin
		if (rst)
			en_q <= 1'b0;
		else if (bus.wr && bus.addr == ADDR_OUTCTL)
			en_q <= bus.wdata[OUT_EN];
	end
	always_ff @(posedge clk) begin
		if (rst)
			mode_q <= 2'h0;
		else if (bus.wr && bus.addr == ADDR_MODE)
			mode_q <= bus.wdata[MODE_HI:MODE_LO];
	end
	always_ff @(posedge clk) begin
		if (rst)
			stop_q <= 2'h3;
		else
			stop_q <= {stop_q[0], mode_q == 2'h0};
	end
	rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data outside read slot");
	cmd_read_a: assert property ($past(bus.rd) &&
		$past(bus.addr) == ADDR_OUTCTL |-> rdata[3:2] == 2'h0)
		else $error("level command bits read nonzero");
	trig_read_a: assert property ($past(bus.rd) &&
		$past(bus.addr) == ADDR_OUTCTL |-> !rdata[OUT_OS_TRIG])
		else $error("one-shot trigger read nonzero");
	cap_resv_a: assert property ($past(bus.rd) &&
		$past(bus.addr) == ADDR_CAPCTL |-> rdata[7:3] == 5'h00)
		else $error("capture control spare bits set");
	mode_resv_a: assert property ($past(bus.rd) &&
		$past(bus.addr) == ADDR_MODE |-> rdata[7:4] == 4'h0)
		else $error("mode spare bits set");
	pin_off_a: assert property (!en_q && !$past(en_q) |-> !timer_output_pin)
		else $error("pin high while output disabled");
	stop_quiet_a: assert property (stop_q == 2'h3 && mode_q == 2'h0
		|-> irq == 2'h0)
		else $error("event while stopped");
	match_pulse_a: assert property (irq.match1 |=> !irq.match1)
		else $error("match one event longer than a cycle");
	stop_clear_a: assert property (stop_q == 2'h3 && $past(bus.rd) &&
		$past(bus.addr) == ADDR_CNT_LO |-> rdata == 8'h00)
		else $error("counter nonzero while stopped");
endmodule : tcc_timer_props
bind tcc_timer tcc_timer_props u_props (.clk(clk), .rst(rst), .bus(bus),
	.rdata(rdata), .timer_input_zero(timer_input_zero),
	.timer_input_one(timer_input_one),
	.timer_output_pin(timer_output_pin), .irq(irq));

/* File: bench/testbench.sv */
// Self-checking bench for the timer: registers, events, output pin.
// Assumes tcc_timer with its checker bound to it.
`timescale 1ns/1ns
module testbench import tcc_pkg::*;;
	typedef struct packed {
		logic [15:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} tcc_row_type;
	logic clk, rst, in0, in1, pin, p;
	logic [7:0] rdata, d;
	tcc_bus_type bus;
	tcc_irq_type irq;
	int fails = 0, n_checks = 0, n;
	logic [15:0] ra[4] = '{ADDR_MODE, ADDR_CAPCTL, ADDR_OUTCTL, ADDR_PRESC};
	tcc_row_type rows[10] = '{'{ADDR_MODE, 8'hF2, 8'h02},
		'{ADDR_CAPCTL, 8'hFF, 8'h07}, '{ADDR_OUTCTL, 8'h3C, 8'h30},
		'{ADDR_OUTCTL, 8'h00, 8'h00}, '{ADDR_PRESC, 8'hFF, 8'hF3},
		'{ADDR_PRESC, 8'h00, 8'h00}, '{ADDR_CAPCTL, 8'h00, 8'h00},
		'{ADDR_CR1_LO, 8'h5A, 8'h5A}, '{16'hFF70, 8'hFF, 8'h00},
		'{ADDR_CNT_LO, 8'h55, 8'h00}};
	tcc_timer u_tcc_timer (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
		.timer_input_zero(in0), .timer_input_one(in1),
		.timer_output_pin(pin), .irq(irq));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 v = rdata;
	endtask : rd
	// Bounded wait for a match zero event; n is the edges waited
	task automatic wait_m0;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (irq.match0 !== 1'b1 && n < 100);
	endtask : wait_m0
	task automatic lvl(input logic [7:0] v, input logic e);
		wr(ADDR_OUTCTL, v);
		repeat (3) @(posedge clk);
		check({7'h00, pin}, {7'h00, e});
	endtask : lvl
	initial begin
		#100000;
		fails++;
		test_done;
	end
	initial begin
		bus = '0;
		in0 = 1'b0;
		in1 = 1'b0;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (ra[i]) begin
			rd(ra[i], d);
			check(d, RESET_BYTE);
		end
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, d);
			check(d, rows[i].e);
		end
		// Match-clear at 3, osc/2: one event every 8 cycles
		wr(ADDR_CR0_LO, 8'h03);
		wr(ADDR_CR1_LO, 8'h01);
		wr(ADDR_OUTCTL, 8'h01);
		wr(ADDR_OUTCTL, 8'h03);
		wr(ADDR_MODE, 8'h0C);
		wait_m0;
		wait_m0;
		check(n[7:0], 8'h08);
		repeat (3) @(posedge clk);
		p = pin;
		wait_m0;
		repeat (3) @(posedge clk);
		check({7'h00, pin}, {7'h00, ~p});
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_PRESC, 8'h01);
		wr(ADDR_MODE, 8'h0C);
		wait_m0;
		wait_m0;
		check(n[7:0], 8'h10);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_OUTCTL, 8'h01);
		wr(ADDR_MODE, 8'h0C);
		p = pin;
		wait_m0;
		repeat (3) @(posedge clk);
		check({7'h00, pin}, {7'h00, p});
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_OUTCTL, 8'h11);
		wr(ADDR_MODE, 8'h0C);
		p = pin;
		repeat (12) @(posedge clk);
		check({7'h00, pin}, {7'h00, ~p});
		wr(ADDR_MODE, 8'h00);
		lvl(8'h05, 1'b0);
		lvl(8'h09, 1'b1);
		lvl(8'h0D, 1'b1);
		lvl(8'h00, 1'b0);
		// Capture into register zero from input one rising
		wr(ADDR_PRESC, 8'h40);
		wr(ADDR_CAPCTL, 8'h01);
		wr(ADDR_CR0_LO, 8'h00);
		wr(ADDR_MODE, 8'h04);
		repeat (20) @(posedge clk);
		in1 <= 1'b1;
		wait_m0;
		check({7'h00, irq.match0}, 8'h01);
		rd(ADDR_CR0_LO, d);
		check({7'h00, d == 8'h00}, 8'h00);
		wr(ADDR_MODE, 8'h00);
		// Both edges on input zero: capture must stay silent
		wr(ADDR_CAPCTL, 8'h03);
		wr(ADDR_PRESC, 8'h30);
		wr(ADDR_MODE, 8'h04);
		in0 <= 1'b1;
		repeat (10) @(posedge clk);
		in0 <= 1'b0;
		wait_m0;
		check({7'h00, irq.match0}, 8'h00);
		wr(ADDR_MODE, 8'h00);
		// Input zero rising edge toggles the pin when timing bit is set
		wr(ADDR_CAPCTL, 8'h00);
		wr(ADDR_OUTCTL, 8'h01);
		wr(ADDR_PRESC, 8'h10);
		wr(ADDR_MODE, 8'h06);
		p = pin;
		in0 <= 1'b1;
		repeat (6) @(posedge clk);
		check({7'h00, pin}, {7'h00, ~p});
		wr(ADDR_MODE, 8'h00);
		test_done;
	end
endmodule : testbench
